// [dem_pkg.sv]
// Constants shared by the device-enable mirror block and its helpers.
// Assumes configuration offsets are byte addresses of aligned dwords.
package dem_pkg;
	localparam int CFG_DATA_W = 32;
	localparam int CFG_BE_W = 4;
	localparam int CFG_OFF_W = 8;
	localparam int CFG_BUS_W = 8;
	localparam int CFG_DEV_W = 5;
	localparam int CFG_FUNC_W = 3;
	localparam int SUBCLASS_W = 8;

	localparam logic [CFG_BUS_W-1:0] OWN_BUS = 8'h00;
	localparam logic [CFG_DEV_W-1:0] GFX_DEV = 5'h02;
	localparam logic [CFG_FUNC_W-1:0] GFX_FN0 = 3'h0;

	localparam logic [CFG_OFF_W-1:0] OFF_MIRROR = 8'h54;
	localparam logic [CFG_OFF_W-1:0] OFF_SCRATCH = 8'h58;
	localparam int DWORD_LSB = 2;

	localparam int BIT_HOST = 0;
	localparam int BIT_PORT = 1;
	localparam int BIT_FN0 = 3;
	localparam int BIT_FN1 = 4;

	localparam logic [CFG_DATA_W-1:0] MIRROR_RST = 32'h0000_001b;
	localparam logic [CFG_DATA_W-1:0] MIRROR_WR_MASK = 32'h0000_001a;
	localparam logic [CFG_DATA_W-1:0] MIRROR_HARD_ONE = 32'h0000_0001;
	localparam logic [CFG_DATA_W-1:0] SCRATCH_RST = 32'h0000_0000;
	localparam logic [CFG_DATA_W-1:0] RDATA_NONE = 32'h0000_0000;

	localparam logic [SUBCLASS_W-1:0] SUBCLASS_VGA = 8'h00;
	localparam logic [SUBCLASS_W-1:0] SUBCLASS_OTHER = 8'h80;
endpackage

// [dem_acc_if.sv]
// Decoded configuration access passed from the decoder to the register bank.
// Assumes both ends sit in the same clock domain.
interface dem_acc_if;
	logic                            take;
	logic                            write;
	logic                            hit_mirror;
	logic                            hit_scratch;
	logic [dem_pkg::CFG_BE_W-1:0]    be;
	logic [dem_pkg::CFG_DATA_W-1:0]  wdata;

	modport decoder (
		output take,
		output write,
		output hit_mirror,
		output hit_scratch,
		output be,
		output wdata
	);
	modport regs (
		input take,
		input write,
		input hit_mirror,
		input hit_scratch,
		input be,
		input wdata
	);
endinterface

// [dem_byte_merge.sv]
// Byte-lane merge of write data over an old register value.
// Assumes byte enables are active high, one per lane.
module dem_byte_merge #(
	parameter int BYTES = dem_pkg::CFG_BE_W
) (
	input  wire logic [8*BYTES-1:0] old_value,
	input  wire logic [8*BYTES-1:0] wdata,
	input  wire logic [BYTES-1:0]   be,
	output logic      [8*BYTES-1:0] merged
);
	for (genvar i = 0; i < BYTES; i++) begin : g_lane
		assign merged[8*i +: 8] = be[i] ? wdata[8*i +: 8] : old_value[8*i +: 8];
	end
endmodule

// [dem_cfg_decode.sv]
// Configuration cycle decoder for the mirror and scratch registers.
// Assumes requests are one-cycle strobes synchronous to the clock.
module dem_cfg_decode (
	input  wire logic                              cfg_valid,
	input  wire logic                              cfg_write,
	input  wire logic [dem_pkg::CFG_BUS_W-1:0]     cfg_bus,
	input  wire logic [dem_pkg::CFG_DEV_W-1:0]     cfg_dev,
	input  wire logic [dem_pkg::CFG_FUNC_W-1:0]    cfg_func,
	input  wire logic [dem_pkg::CFG_OFF_W-1:0]     cfg_offset,
	input  wire logic [dem_pkg::CFG_BE_W-1:0]      cfg_be,
	input  wire logic [dem_pkg::CFG_DATA_W-1:0]    cfg_wdata,
	input  wire logic                              fn0_visible,
	dem_acc_if.decoder                             acc
);
	function automatic logic same_dword(
		input logic [dem_pkg::CFG_OFF_W-1:0] a,
		input logic [dem_pkg::CFG_OFF_W-1:0] b
	);
		same_dword = a[dem_pkg::CFG_OFF_W-1:dem_pkg::DWORD_LSB]
			== b[dem_pkg::CFG_OFF_W-1:dem_pkg::DWORD_LSB];
	endfunction

	logic our_func;

	// A hidden function claims nothing, so enumeration never finds it.
	assign our_func = cfg_valid && fn0_visible
		&& cfg_bus == dem_pkg::OWN_BUS
		&& cfg_dev == dem_pkg::GFX_DEV
		&& cfg_func == dem_pkg::GFX_FN0;
	assign acc.hit_mirror = our_func
		&& same_dword(cfg_offset, dem_pkg::OFF_MIRROR);
	assign acc.hit_scratch = our_func
		&& same_dword(cfg_offset, dem_pkg::OFF_SCRATCH);
	assign acc.take = acc.hit_mirror || acc.hit_scratch;
	assign acc.write = cfg_write;
	assign acc.be = cfg_be;
	assign acc.wdata = cfg_wdata;
endmodule

// [dem_top.sv]
// Device-enable mirror and software scratch registers of graphics function 0.
// Assumes one clock, synchronous straps, and requests as one-cycle strobes.
//
// Functional notes
// - VGA decode on: claim legacy VGA cycles, report sub-class 00.
// - VGA decode off: claim no VGA cycles, report sub-class 80.
// - Bit 4 enables graphics function 1; resets to 1.
// - Function 1 is hidden whenever function 0 is hidden.
// - Bit 3 enables graphics function 0; resets to 1.
// - Without graphics capability, function 0 stays hidden regardless of bit 3.
// - Bit 1 clear hides the port, gates its clock, asserts its reset.
// - Reset clears port enable if capability absent or strap combination says so.
// - Bit 0, the host bridge, always reads 1.
// - Mirror at 54h, 32 bits, resets 0000001Bh, unused bits read 0.
// - Trusted mode makes every writable mirror bit read-only.
// - Scratch at 58h, 32 bits, read-write, no effect, resets to 0.
module dem_top (
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	input  wire logic                              cap_gfx_present,
	input  wire logic                              cap_port_present,
	input  wire logic                              strap_serial_video,
	input  wire logic                              strap_concurrent,
	input  wire logic                              trusted_mode,
	input  wire logic                              vga_decode_off,
	input  wire logic                              vga_cycle,
	input  wire logic                              cfg_valid,
	input  wire logic                              cfg_write,
	input  wire logic [dem_pkg::CFG_BUS_W-1:0]     cfg_bus,
	input  wire logic [dem_pkg::CFG_DEV_W-1:0]     cfg_dev,
	input  wire logic [dem_pkg::CFG_FUNC_W-1:0]    cfg_func,
	input  wire logic [dem_pkg::CFG_OFF_W-1:0]     cfg_offset,
	input  wire logic [dem_pkg::CFG_BE_W-1:0]      cfg_be,
	input  wire logic [dem_pkg::CFG_DATA_W-1:0]    cfg_wdata,
	output logic                                   cfg_done,
	output logic                                   cfg_claimed,
	output logic      [dem_pkg::CFG_DATA_W-1:0]    cfg_rdata,
	output logic                                   host_visible,
	output logic                                   port_visible,
	output logic                                   port_clk_en,
	output logic                                   port_internal_reset_n,
	output logic                                   gfx_fn0_visible,
	output logic                                   gfx_fn1_visible,
	output logic                                   vga_claim,
	output logic      [dem_pkg::SUBCLASS_W-1:0]    gfx_subclass
);
	dem_acc_if acc ();

	logic [dem_pkg::CFG_DATA_W-1:0]   mirror;
	logic [dem_pkg::CFG_DATA_W-1:0]   scratch;
	logic                             gfx_cap;
	logic [dem_pkg::CFG_DATA_W-1:0]   mirror_view;
	logic [dem_pkg::CFG_DATA_W-1:0]   mirror_merged;
	logic [dem_pkg::CFG_DATA_W-1:0]   scratch_merged;
	logic [dem_pkg::CFG_DATA_W-1:0]   next_mirror;
	logic [dem_pkg::CFG_DATA_W-1:0]   next_scratch;
	logic [dem_pkg::CFG_DATA_W-1:0]   reset_mirror;
	logic [dem_pkg::CFG_DATA_W-1:0]   read_sel;
	logic                             port_strap_off;
	logic                             mirror_wr;
	logic                             scratch_wr;
	logic                             gfx_fn0_on;
	logic                             gfx_fn1_on;
	logic                             gfx_port_on;
	logic                             fn0_live;

	dem_cfg_decode u_decode (
		.cfg_valid   (cfg_valid),
		.cfg_write   (cfg_write),
		.cfg_bus     (cfg_bus),
		.cfg_dev     (cfg_dev),
		.cfg_func    (cfg_func),
		.cfg_offset  (cfg_offset),
		.cfg_be      (cfg_be),
		.cfg_wdata   (cfg_wdata),
		.fn0_visible (fn0_live),
		.acc         (acc.decoder)
	);

	dem_byte_merge #(
		.BYTES (dem_pkg::CFG_BE_W)
	) u_merge_mirror (
		.old_value (mirror),
		.wdata     (acc.wdata),
		.be        (acc.be),
		.merged    (mirror_merged)
	);

	dem_byte_merge #(
		.BYTES (dem_pkg::CFG_BE_W)
	) u_merge_scratch (
		.old_value (scratch),
		.wdata     (acc.wdata),
		.be        (acc.be),
		.merged    (scratch_merged)
	);

	// The strap pair is only looked at while reset is held, so later
	// strap movement cannot change which devices exist.
	assign port_strap_off = !cap_port_present
		|| (strap_serial_video && !strap_concurrent);
	assign reset_mirror = port_strap_off
		? (dem_pkg::MIRROR_RST & ~(dem_pkg::MIRROR_HARD_ONE << dem_pkg::BIT_PORT))
		: dem_pkg::MIRROR_RST;

	// Field bits of the mirror.
	assign gfx_fn0_on = mirror[dem_pkg::BIT_FN0];
	assign gfx_fn1_on = mirror[dem_pkg::BIT_FN1];
	assign gfx_port_on = mirror[dem_pkg::BIT_PORT];

	// Capability overrides the enable bit without altering what it reads.
	assign fn0_live = gfx_fn0_on && gfx_cap;

	// Only the three enable bits are stored; bit 0 is forced and every
	// other bit is masked so reserved positions read zero.
	assign mirror_view = (mirror & dem_pkg::MIRROR_WR_MASK)
		| dem_pkg::MIRROR_HARD_ONE;

	// Writes into the mirror are dropped while trusted mode holds.
	assign mirror_wr = acc.take && acc.write && acc.hit_mirror && !trusted_mode;
	assign scratch_wr = acc.take && acc.write && acc.hit_scratch;

	assign next_mirror = mirror_wr
		? (mirror_merged & dem_pkg::MIRROR_WR_MASK) | dem_pkg::MIRROR_HARD_ONE
		: mirror;
	assign next_scratch = scratch_wr ? scratch_merged : scratch;

	assign read_sel = acc.hit_mirror ? mirror_view
		: acc.hit_scratch ? scratch
		: dem_pkg::RDATA_NONE;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mirror <= reset_mirror;
			scratch <= dem_pkg::SCRATCH_RST;
			gfx_cap <= cap_gfx_present;
		end else begin
			mirror <= next_mirror;
			scratch <= next_scratch;
		end
	end

	// Answer one cycle after every request; unclaimed ones read zero.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_done <= 1'b0;
			cfg_claimed <= 1'b0;
			cfg_rdata <= dem_pkg::RDATA_NONE;
		end else begin
			cfg_done <= cfg_valid;
			cfg_claimed <= acc.take;
			cfg_rdata <= (acc.take && !acc.write) ? read_sel : dem_pkg::RDATA_NONE;
		end
	end

	// Visibility and port control are registered so glitches on the
	// capability path never reach the port's clock gate or reset.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			host_visible <= 1'b0;
			port_visible <= 1'b0;
			port_clk_en <= 1'b0;
			port_internal_reset_n <= 1'b0;
			gfx_fn0_visible <= 1'b0;
			gfx_fn1_visible <= 1'b0;
		end else begin
			host_visible <= mirror_view[dem_pkg::BIT_HOST];
			port_visible <= gfx_port_on;
			port_clk_en <= gfx_port_on;
			port_internal_reset_n <= gfx_port_on;
			gfx_fn0_visible <= fn0_live;
			gfx_fn1_visible <= gfx_fn1_on && fn0_live;
		end
	end

	// Legacy VGA claim; a hidden function 0 claims nothing either.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vga_claim <= 1'b0;
			gfx_subclass <= dem_pkg::SUBCLASS_VGA;
		end else begin
			vga_claim <= vga_cycle && !vga_decode_off && fn0_live;
			gfx_subclass <= vga_decode_off
				? dem_pkg::SUBCLASS_OTHER
				: dem_pkg::SUBCLASS_VGA;
		end
	end
endmodule

// [dem_top_props.sv]
// Concurrent checks on the ports of the device-enable mirror block.
// Assumes one clock domain and a synchronous active-low reset.
module dem_top_props (
	input wire logic                          clk,
	input wire logic                          rst_n,
	input wire logic                          vga_decode_off,
	input wire logic                          vga_cycle,
	input wire logic                          cfg_valid,
	input wire logic                          cfg_write,
	input wire logic [dem_pkg::CFG_DEV_W-1:0] cfg_dev,
	input wire logic [dem_pkg::CFG_OFF_W-1:0] cfg_offset,
	input wire logic                          cfg_done,
	input wire logic                          cfg_claimed,
	input wire logic [dem_pkg::CFG_DATA_W-1:0] cfg_rdata,
	input wire logic                          host_visible,
	input wire logic                          port_visible,
	input wire logic                          port_clk_en,
	input wire logic                          port_internal_reset_n,
	input wire logic                          gfx_fn0_visible,
	input wire logic                          gfx_fn1_visible,
	input wire logic                          vga_claim,
	input wire logic [dem_pkg::SUBCLASS_W-1:0] gfx_subclass
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_done;
		cfg_valid |=> cfg_done;
	endproperty
	a_done: assert property (p_done) else $error("request not answered");
	property p_host;
		rst_n && $past(rst_n) |-> host_visible;
	endproperty
	a_host: assert property (p_host) else $error("host bridge hidden");
	property p_fn1;
		gfx_fn1_visible |-> gfx_fn0_visible;
	endproperty
	a_fn1: assert property (p_fn1) else $error("fn1 seen without fn0");
	property p_port;
		port_clk_en == port_visible && port_internal_reset_n == port_visible;
	endproperty
	a_port: assert property (p_port) else $error("port gating mismatch");
	property p_vga_on;
		vga_cycle && !vga_decode_off ##1 gfx_fn0_visible |-> vga_claim;
	endproperty
	a_vga_on: assert property (p_vga_on) else $error("vga unclaimed");
	property p_vga_off;
		!(vga_cycle && !vga_decode_off) |=> !vga_claim;
	endproperty
	a_vga_off: assert property (p_vga_off) else $error("vga claimed");
	property p_sub;
		rst_n && $past(rst_n) |->
			gfx_subclass == ($past(vga_decode_off) ? 8'h80 : 8'h00);
	endproperty
	a_sub: assert property (p_sub) else $error("bad sub-class");
	property p_unmapped;
		cfg_valid && cfg_dev != 5'h02 |=> !cfg_claimed && cfg_rdata == 0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("foreign claim");
	property p_mirror;
		cfg_valid && !cfg_write && cfg_offset[7:2] == 6'h15 |=> !cfg_claimed
			|| (cfg_rdata[0] && (cfg_rdata & 32'hffff_ffe4) == 0);
	endproperty
	a_mirror: assert property (p_mirror) else $error("bad mirror read");
	c_read: cover property (cfg_done && cfg_claimed);
	c_vga: cover property (vga_claim);
	c_port_off: cover property (!port_internal_reset_n);
endmodule
bind dem_top dem_top_props u_props (.clk, .rst_n, .vga_decode_off,
	.vga_cycle, .cfg_valid, .cfg_write, .cfg_dev, .cfg_offset, .cfg_done,
	.cfg_claimed, .cfg_rdata, .host_visible, .port_visible, .port_clk_en,
	.port_internal_reset_n, .gfx_fn0_visible, .gfx_fn1_visible,
	.vga_claim, .gfx_subclass);

// [dem_host_model.sv]
// Host software model issuing single configuration accesses.
// Assumes the block answers one cycle after the request edge.
module dem_host_model (
	input  wire logic        clk,
	input  wire logic        cfg_done,
	input  wire logic        cfg_claimed,
	input  wire logic [31:0] cfg_rdata,
	output logic             cfg_valid,
	output logic             cfg_write,
	output logic [15:0]      cfg_tgt,
	output logic [7:0]       cfg_offset,
	output logic [3:0]       cfg_be,
	output logic [31:0]      cfg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cfg_valid = 1'b0;
		cfg_write = 1'b0;
		cfg_tgt = 16'h0000;
		cfg_offset = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0000_0000;
	end
	// Missing answer turns the claim flag unknown, so it cannot match.
	task automatic acc(input logic w, input logic [15:0] t,
		input logic [7:0] o, input logic [3:0] b, input logic [31:0] d,
		output logic cl, output logic [31:0] rd);
		@(posedge clk);
		cfg_valid <= 1'b1;
		cfg_write <= w;
		cfg_tgt <= t;
		cfg_offset <= o;
		cfg_be <= b;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_valid <= 1'b0;
		cfg_wdata <= ~d;
		@(negedge clk);
		cl = cfg_done ? cfg_claimed : 1'bx;
		rd = cfg_rdata;
	endtask
endmodule

// [test_device_enable_mirror_regs.sv]
// Self-checking bench for the device-enable mirror block.
// Assumes the host model drives every configuration request.
module test_device_enable_mirror_regs;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] GFX = 16'h0010;
	logic clk, rst_n, cap_gfx_present, cap_port_present, strap_serial_video;
	logic strap_concurrent, trusted_mode, vga_decode_off, vga_cycle;
	logic cfg_valid, cfg_write, cfg_done, cfg_claimed, cl;
	logic [15:0] tgt;
	logic [7:0] cfg_offset, gfx_subclass;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, rv;
	logic host_visible, port_visible, port_clk_en, port_internal_reset_n;
	logic gfx_fn0_visible, gfx_fn1_visible, vga_claim;
	int mismatches = 0;
	int total_checks = 0;
	dem_top DUT (.clk, .rst_n, .cap_gfx_present, .cap_port_present,
		.strap_serial_video, .strap_concurrent, .trusted_mode,
		.vga_decode_off, .vga_cycle, .cfg_valid, .cfg_write,
		.cfg_bus(tgt[15:8]), .cfg_dev(tgt[7:3]), .cfg_func(tgt[2:0]),
		.cfg_offset, .cfg_be, .cfg_wdata, .cfg_done, .cfg_claimed,
		.cfg_rdata, .host_visible, .port_visible, .port_clk_en,
		.port_internal_reset_n, .gfx_fn0_visible, .gfx_fn1_visible,
		.vga_claim, .gfx_subclass);
	dem_host_model host (.clk, .cfg_done, .cfg_claimed, .cfg_rdata,
		.cfg_valid, .cfg_write, .cfg_tgt(tgt), .cfg_offset, .cfg_be,
		.cfg_wdata);
	always #50 clk = ~clk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic do_reset(input logic [3:0] s);
		@(posedge clk);
		{cap_gfx_present, cap_port_present, strap_serial_video,
			strap_concurrent} <= s;
		rst_n <= 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge clk);
	endtask
	task automatic vis(input logic [5:0] e);
		chk({host_visible, port_visible, port_clk_en, port_internal_reset_n,
			gfx_fn0_visible, gfx_fn1_visible}, {26'h0, e});
	endtask
	task automatic t_vga();
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			vga_decode_off <= i[0];
			vga_cycle <= 1'b1;
			@(posedge clk);
			vga_cycle <= 1'b0;
			@(negedge clk);
			chk(vga_claim, !i[0]);
			chk(gfx_subclass, i[0] ? 8'h80 : 8'h00);
		end
	endtask
	task automatic t_scratch();
		host.acc(1, GFX, 8'h58, 4'hf, 32'ha5a5_5a5a, cl, rv);
		chk(cl, 1'b1);
		host.acc(1, GFX, 8'h5b, 4'h8, 32'hffff_0000, cl, rv);
		host.acc(0, GFX, 8'h58, 4'h0, 32'h0000_0000, cl, rv);
		chk(rv, 32'hffa5_5a5a);
	endtask
	task automatic t_mirror();
		@(posedge clk);
		trusted_mode <= 1'b1;
		host.acc(1, GFX, 8'h54, 4'hf, 32'h0000_0000, cl, rv);
		@(posedge clk);
		trusted_mode <= 1'b0;
		host.acc(0, GFX, 8'h54, 4'h0, 32'h0000_0000, cl, rv);
		chk(rv, 32'h0000_001b);
		host.acc(1, GFX, 8'h54, 4'hf, 32'hffff_ffff, cl, rv);
		host.acc(0, GFX, 8'h54, 4'h0, 32'h0000_0000, cl, rv);
		chk(rv, 32'h0000_001b);
		host.acc(1, GFX, 8'h54, 4'h1, 32'h0000_000b, cl, rv);
		host.acc(0, GFX, 8'h54, 4'h0, 32'h0000_0000, cl, rv);
		chk(rv, 32'h0000_000b);
		vis(6'h3e);
		host.acc(1, GFX, 8'h54, 4'h1, 32'h0000_0010, cl, rv);
		repeat (2) @(negedge clk);
		vis(6'h20);
		host.acc(0, GFX, 8'h54, 4'h0, 32'h0000_0000, cl, rv);
		chk(cl, 1'b0);
		chk(rv, 32'h0000_0000);
	endtask
	task automatic t_straps();
		do_reset(4'he);
		host.acc(0, GFX, 8'h54, 4'h0, 32'h0000_0000, cl, rv);
		chk(rv, 32'h0000_0019);
		vis(6'h23);
		do_reset(4'h8);
		host.acc(0, GFX, 8'h54, 4'h0, 32'h0000_0000, cl, rv);
		chk(rv, 32'h0000_0019);
		do_reset(4'h4);
		vis(6'h3c);
		host.acc(0, GFX, 8'h58, 4'h0, 32'h0000_0000, cl, rv);
		chk(cl, 1'b0);
	endtask
	task automatic stop_test();
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// The whole run needs about a hundred cycles; the margin is generous.
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		stop_test();
	end
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		trusted_mode = 1'b0;
		vga_decode_off = 1'b0;
		vga_cycle = 1'b0;
		do_reset(4'hc);
		host.acc(0, GFX, 8'h54, 4'h0, 32'h0000_0000, cl, rv);
		chk(rv, 32'h0000_001b);
		vis(6'h3f);
		host.acc(0, 16'h0011, 8'h58, 4'h0, 32'h0000_0000, cl, rv);
		chk(cl, 1'b0);
		host.acc(0, 16'h0008, 8'h54, 4'h0, 32'h0000_0000, cl, rv);
		chk(cl, 1'b0);
		chk(rv, 32'h0000_0000);
		host.acc(0, 16'h0110, 8'h54, 4'h0, 32'h0000_0000, cl, rv);
		chk(cl, 1'b0);
		t_vga();
		t_scratch();
		t_mirror();
		t_straps();
		stop_test();
	end
endmodule
